//--- logic/sec_event_map.svh
`ifndef SEC_EVENT_MAP_SVH
`define SEC_EVENT_MAP_SVH
`define FRM_HEADER      8'hFF
`define FRM_ESCAPE      8'hFE
`define FRM_ACK         8'h06
`define FRM_NACK        8'h15
`define ADDR_CMD        8'h47
`define OP_JOINCTL      8'h10
`define OP_KEY_WRITE    8'h11
`define OP_KEY_CLEAR    8'h12
`define OP_KEY_RELOAD   8'h13
`define OP_FACTORY_RESTORE 8'h20
`define NVR_SIZE        8'h07
`define NVR_CONF1       8'h2A
`define NVR_CONF2       8'h3B
`define CLR_SIZE        8'h04
`define KSEL_VOL        8'h01
`define KSEL_NV         8'h02
`define ESC_HIGH_BIT    8'h80
`define RD_SEC_STATUS   8'hC9
`define RD_JOIN_STATUS  8'hCA
`define ADDR_NVMASK2    8'h80
`define ADDR_NVMASK1    8'h81
`define ADDR_NVMASK0    8'h82
`define ADDR_FLAG2      8'hCD
`define ADDR_FLAG1      8'hCE
`define ADDR_FLAG0      8'hCF
`define ADDR_MASK2      8'hD0
`define ADDR_MASK1      8'hD1
`define ADDR_MASK0      8'hD2
`define ADDR_PKT_OPTIONS 8'hD3
`define ADDR_SEC_OPTIONS 8'hD4
`define SEC_VOLKEY_BIT  1
`define SEC_NVKEY_BIT   2
`define JOIN_WAIT       8'h21
`define JOIN_PROGRESS   8'h22
`define JOIN_ACTIVE_ADD 8'h64
`define SEC_OPT_PLAIN_BIT 5
`define FLAG1_USED      8'h3F
`define FLAG2_USED      8'h00
`define FLAG0_USED      8'hFF
`define KEY_BYTES       16
`define KEY_IDX_W       4
`define MSG_LEN         23
`endif

//--- logic/sec_event_pkg.sv
`include "sec_event_map.svh"
package sec_event_pkg;
  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_SIZE   = 4'b0001,
    ST_ESC1   = 4'b0010,
    ST_ADDR   = 4'b0011,
    ST_VALUE  = 4'b0100,
    ST_EXTRA  = 4'b0101,
    ST_KEY    = 4'b0110,
    ST_RESP0  = 4'b0111,
    ST_RESP1  = 4'b1000,
    ST_RESP2  = 4'b1001,
    ST_MSG    = 4'b1010,
    ST_RESET  = 4'b1011
  } cmd_state_e;
  typedef logic [7:0] byte_t;
endpackage

//--- logic/key_store.sv
`include "sec_event_map.svh"
module key_store
  import sec_event_pkg::*;
#(
  parameter int NBYTES = `KEY_BYTES,
  parameter int AW     = `KEY_IDX_W
) (
  input  wire logic          mclk_i,
  input  wire logic          arst_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic [7:0]         rdata_o,
  output logic               nonzero_o
);
  logic [7:0] mem_r [NBYTES];
  logic [NBYTES-1:0] nz_r;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end

  // Presence bits live with the key, across resets
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
      nz_r[waddr_i]  <= (wdata_i != 8'h00);
    end
  end

  // All-zero key means no key
  assign nonzero_o = |nz_r;
endmodule

//--- logic/sec_event_regs.sv
`include "sec_event_map.svh"
// Function
// - Key-write frame stores sixteen key bytes
// - Selector one volatile, two non-volatile
// - Clear-key frame zeroes selected key
// - Reload copies stored key into working key
// - Factory frame restores non-volatile defaults
// - Send reset text, then full reset
// - Security status read answers ack, C9, value
// - Bit1 volatile key, bit2 non-volatile key
// - Join status read at 4A answers CA
// - Join status 21, 22, plus 64 active
// - Events set matching secondary flag bits
// - Reads keep flags; writes never set
// - Flag write stores AND with current value
// - Fault line from masked flags, legacy zero
// - Volatile and non-volatile mask bytes
// - Transmit-complete set after send or ack
// - Receive-pending follows undelivered byte count
// - Plaintext flag only when plaintext accepted
// - Sequence decrease sets its flag
// - Sequence gap over one sets its flag
// - Lowest flag byte error bit map
// - Join start sets bit five; rest reserved
// - Join active refuses writes except halt
// - Zero key absent; volatile loaded at start
module sec_event_regs
  import sec_event_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       arst_n_i,
  input  wire logic       rx_valid_i,
  input  wire logic [7:0] rx_data_i,
  input  wire logic       tx_ready_i,
  output logic            tx_valid_o,
  output logic [7:0]      tx_data_o,
  output logic            full_reset_o,
  input  wire logic [7:0] legacy_event_mask_i,
  input  wire logic [7:0] event_err_i,
  input  wire logic       tx_packet_done_i,
  input  wire logic       ack_requested_i,
  input  wire logic       ack_received_i,
  input  wire logic       rx_bytes_pending_i,
  input  wire logic       rx_plain_pkt_i,
  input  wire logic       rx_enc_pkt_i,
  input  wire logic [7:0] rx_seq_i,
  input  wire logic       join_start_i,
  input  wire logic       join_peer_seen_i,
  input  wire logic       join_done_i,
  output logic            fault_notice_line_o,
  output logic            join_active_indication_o,
  output logic [7:0]      packet_options_o
);
  cmd_state_e st_r, st_nxt;
  logic [7:0] size_r, addr_r, op_r, ksel_r, rsp_r, flag0_r, flag1_r, flag2_r;
  logic [7:0] vm0_r, vm1_r, vm2_r, nm0_r, nm1_r, nm2_r, sec_opts_r, pkt_opts_r;
  logic [7:0] seq_r, join_st_r;
  logic [4:0] cnt_r;
  logic       esc2_r, seq_ok_r, join_act_r, tx_wait_r, loading_r, reload_r, nak_r;
  logic       wr_ok_r;

  // Frame byte classification
  wire logic  rx = rx_valid_i;
  wire logic  is_hdr = rx && (rx_data_i == `FRM_HEADER);
  wire logic  is_esc = rx && (rx_data_i == `FRM_ESCAPE);
  wire logic [7:0] eff_addr = esc2_r ? (rx_data_i | `ESC_HIGH_BIT) : rx_data_i;
  wire logic  is_cmd = (addr_r == (`ADDR_CMD | `ESC_HIGH_BIT));
  wire logic  halt_cmd = is_cmd && (op_r == `OP_JOINCTL) && (rx_data_i == 8'h00);
  wire logic  locked = join_act_r;
  wire logic  key_last = (cnt_r == 5'(`KEY_BYTES - 1));
  wire logic  is_read = (size_r == 8'h02) || (size_r == 8'h03 && esc2_r);

  // Key memories: working and stored default
  logic       kv_we, kn_we;
  logic [3:0] kv_wa, kn_wa, k_ra;
  logic [7:0] kv_wd, kn_wd, kv_rd, kn_rd;
  logic       kv_nz, kn_nz;

  key_store u_vol (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (kv_we),
    .waddr_i  (kv_wa),
    .wdata_i  (kv_wd),
    .raddr_i  (k_ra),
    .rdata_o  (kv_rd),
    .nonzero_o(kv_nz)
  );
  key_store u_nv (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .we_i     (kn_we),
    .waddr_i  (kn_wa),
    .wdata_i  (kn_wd),
    .raddr_i  (k_ra),
    .rdata_o  (kn_rd),
    .nonzero_o(kn_nz)
  );

  // Copy read address leads write by one cycle
  wire logic  copying = loading_r || reload_r;
  wire logic [3:0] cpy_wa = cnt_r[3:0] - 4'h1;
  wire logic  key_byte = (st_r == ST_KEY) && rx;
  wire logic  clr_run = (st_r == ST_EXTRA) && (op_r == `OP_KEY_CLEAR) && wr_ok_r;
  wire logic  nv_wipe = (st_r == ST_MSG) && tx_ready_i && !cnt_r[4];
  assign k_ra  = cnt_r[3:0];
  assign kv_we = (copying && cnt_r != 5'd0)
               || (key_byte && ksel_r == `KSEL_VOL)
               || (clr_run && ksel_r == `KSEL_VOL);
  assign kn_we = ((key_byte || clr_run) && ksel_r == `KSEL_NV)
               || nv_wipe;
  assign kv_wa = copying ? cpy_wa : cnt_r[3:0];
  assign kn_wa = cnt_r[3:0];
  assign kv_wd = copying ? kn_rd : (clr_run ? 8'h00 : rx_data_i);
  assign kn_wd = (clr_run || nv_wipe) ? 8'h00 : rx_data_i;

  // Security and join status values
  wire logic [7:0] sec_stat = (8'(kv_nz) << `SEC_VOLKEY_BIT)
                            | (8'(kn_nz) << `SEC_NVKEY_BIT);
  wire logic [7:0] join_val = join_st_r + (join_act_r ? `JOIN_ACTIVE_ADD : 8'h00);

  // Fault notice
  wire logic any_ev = |({flag2_r & vm2_r, flag1_r & vm1_r, flag0_r & vm0_r});
  assign fault_notice_line_o      = (legacy_event_mask_i == 8'h00) && any_ev;
  assign join_active_indication_o = join_act_r;
  assign packet_options_o         = pkt_opts_r;

  // Reply selection
  function automatic logic [7:0] reg_rd(input logic [7:0] a);
    unique case (a)
      `RD_SEC_STATUS:  reg_rd = sec_stat;
      `RD_JOIN_STATUS: reg_rd = join_val;
      `ADDR_FLAG2:   reg_rd = flag2_r;
      `ADDR_FLAG1:   reg_rd = flag1_r;
      `ADDR_FLAG0:   reg_rd = flag0_r;
      `ADDR_MASK2:   reg_rd = vm2_r;
      `ADDR_MASK1:   reg_rd = vm1_r;
      `ADDR_MASK0:   reg_rd = vm0_r;
      `ADDR_NVMASK2: reg_rd = nm2_r;
      `ADDR_NVMASK1: reg_rd = nm1_r;
      `ADDR_NVMASK0: reg_rd = nm0_r;
      `ADDR_PKT_OPTIONS: reg_rd = pkt_opts_r;
      `ADDR_SEC_OPTIONS: reg_rd = sec_opts_r;
      default:       reg_rd = 8'h00;
    endcase
  endfunction

  // Write strobe for plain register writes, value byte in rx_data_i
  wire logic reg_wr = (st_r == ST_VALUE) && rx && !is_read && !is_cmd && !locked;
  function automatic logic [7:0] and_wr(input logic [7:0] cur, input logic [7:0] used,
                                        input logic hit);
    and_wr = hit ? (cur & rx_data_i & used) : (cur & used);
  endfunction

  // Event sources
  wire logic txd_ev = tx_wait_r ? ack_received_i
                    : (tx_packet_done_i && !ack_requested_i);
  wire logic plain_ev = rx_plain_pkt_i && sec_opts_r[`SEC_OPT_PLAIN_BIT];
  wire logic dec_ev = rx_enc_pkt_i && seq_ok_r && (rx_seq_i < seq_r);
  wire logic gap_ev = rx_enc_pkt_i && seq_ok_r && (rx_seq_i > 8'(seq_r + 8'h01));
  wire logic [7:0] ev1 = {2'b00, join_start_i, gap_ev, dec_ev, plain_ev,
                          rx_bytes_pending_i, txd_ev};
  wire logic [7:0] f0_nxt = and_wr(flag0_r, `FLAG0_USED, reg_wr && addr_r == `ADDR_FLAG0)
                          | event_err_i;
  wire logic [7:0] f1_tmp = and_wr(flag1_r, `FLAG1_USED, reg_wr && addr_r == `ADDR_FLAG1)
                          | ev1;
  wire logic [7:0] f1_nxt = {f1_tmp[7:2], rx_bytes_pending_i, f1_tmp[0]};
  wire logic [7:0] f2_nxt = and_wr(flag2_r, `FLAG2_USED, reg_wr && addr_r == `ADDR_FLAG2);

  // Command framer
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE:  if (is_hdr) st_nxt = ST_SIZE;
      ST_SIZE:  if (rx) st_nxt = ST_ESC1;
      ST_ESC1:  if (rx) st_nxt = is_esc ? ST_ADDR : ST_IDLE;
      ST_ADDR:  if (rx && !(is_esc && !esc2_r)) st_nxt = is_read ? ST_RESP0 : ST_VALUE;
      ST_VALUE: if (rx) begin
        if (!is_cmd || (locked && rx_data_i != `OP_JOINCTL)) st_nxt = ST_RESP0;
        else if (rx_data_i == `OP_KEY_RELOAD) st_nxt = ST_RESP0;
        else st_nxt = ST_EXTRA;
      end
      ST_EXTRA: begin
        if (op_r == `OP_KEY_CLEAR) begin
          if (wr_ok_r && key_last) st_nxt = ST_RESP0;
        end else if (rx) begin
          if (op_r == `OP_KEY_WRITE) st_nxt = ST_KEY;
          else if (op_r == `OP_FACTORY_RESTORE && cnt_r == 5'd3)
            st_nxt = (nak_r || rx_data_i != `NVR_CONF2 || size_r != `NVR_SIZE) ? ST_RESP0
                   : ST_MSG;
          else if (op_r != `OP_FACTORY_RESTORE) st_nxt = ST_RESP0;
        end
      end
      ST_KEY:   if (rx && key_last) st_nxt = ST_RESP0;
      ST_RESP0: if (tx_ready_i) st_nxt = is_read ? ST_RESP1 : ST_IDLE;
      ST_RESP1: if (tx_ready_i) st_nxt = ST_RESP2;
      ST_RESP2: if (tx_ready_i) st_nxt = ST_IDLE;
      ST_MSG:   if (tx_ready_i && cnt_r == 5'(`MSG_LEN - 1)) st_nxt = ST_RESET;
      ST_RESET: st_nxt = ST_RESET;
      default:  st_nxt = ST_IDLE;
    endcase
  end

  // Reset text
  function automatic logic [7:0] msg_ch(input logic [4:0] i);
    logic [183:0] s;
    s = {8'h0D, 8'h0A, "Configuration Reset", 8'h0D, 8'h0A};
    msg_ch = s[8'(`MSG_LEN - 1 - 32'(i)) * 8 +: 8];
  endfunction

  assign tx_valid_o = (st_r == ST_RESP0) || (st_r == ST_RESP1) || (st_r == ST_RESP2)
                    || (st_r == ST_MSG);
  assign tx_data_o  = (st_r == ST_MSG) ? msg_ch(cnt_r)
                    : (st_r == ST_RESP0) ? (nak_r ? `FRM_NACK : `FRM_ACK)
                    : (st_r == ST_RESP1) ? addr_r : rsp_r;
  assign full_reset_o = (st_r == ST_RESET);

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_r <= ST_IDLE;
      {size_r, addr_r, op_r, ksel_r, rsp_r} <= '0;
      {flag0_r, flag1_r, flag2_r, vm0_r, vm1_r, vm2_r} <= '0;
      {nm0_r, nm1_r, nm2_r, pkt_opts_r, seq_r} <= '0;
      sec_opts_r <= 8'h00;
      join_st_r <= 8'h00;
      cnt_r     <= 5'd0;
      {esc2_r, seq_ok_r, join_act_r, tx_wait_r, reload_r, nak_r, wr_ok_r} <= '0;
      loading_r <= 1'b1;
    end else begin
      st_r    <= st_nxt;
      flag0_r <= f0_nxt;
      flag1_r <= f1_nxt;
      flag2_r <= f2_nxt;
      if (tx_packet_done_i) tx_wait_r <= ack_requested_i;
      else if (ack_received_i) tx_wait_r <= 1'b0;
      if (rx_enc_pkt_i) begin
        seq_r    <= rx_seq_i;
        seq_ok_r <= 1'b1;
      end
      if (join_start_i) begin
        join_act_r <= 1'b1;
        join_st_r  <= `JOIN_WAIT;
      end
      if (join_peer_seen_i && join_act_r) join_st_r <= `JOIN_PROGRESS;
      if (join_done_i) join_act_r <= 1'b0;
      if (copying) begin
        cnt_r <= cnt_r + 5'd1;
        if (cnt_r == 5'(`KEY_BYTES)) begin
          {loading_r, reload_r} <= 2'b00;
          cnt_r <= 5'd0;
        end
      end
      unique case (st_r)
        ST_IDLE: begin
          esc2_r  <= 1'b0;
          nak_r   <= 1'b0;
          wr_ok_r <= 1'b0;
        end
        ST_SIZE: if (rx) size_r <= rx_data_i;
        ST_ADDR: if (rx) begin
          if (is_esc && !esc2_r) esc2_r <= 1'b1;
          else begin
            addr_r <= eff_addr | `ESC_HIGH_BIT;
            rsp_r  <= reg_rd(eff_addr | `ESC_HIGH_BIT);
          end
        end
        ST_VALUE: if (rx) begin
          op_r  <= rx_data_i;
          cnt_r <= 5'd0;
          nak_r <= locked && !(is_cmd && rx_data_i == `OP_JOINCTL);
          if (is_cmd && rx_data_i == `OP_KEY_RELOAD && !locked) reload_r <= 1'b1;
          if (reg_wr) begin
            unique case (addr_r)
              `ADDR_MASK2:   vm2_r <= rx_data_i;
              `ADDR_MASK1:   vm1_r <= rx_data_i;
              `ADDR_MASK0:   vm0_r <= rx_data_i;
              `ADDR_NVMASK2: nm2_r <= rx_data_i;
              `ADDR_NVMASK1: nm1_r <= rx_data_i;
              `ADDR_NVMASK0: nm0_r <= rx_data_i;
              `ADDR_PKT_OPTIONS: pkt_opts_r <= rx_data_i;
              `ADDR_SEC_OPTIONS: sec_opts_r <= rx_data_i;
              default:       ;
            endcase
          end
        end
        ST_EXTRA: begin
          if (op_r == `OP_KEY_CLEAR) begin
            if (wr_ok_r) cnt_r <= cnt_r + 5'd1;
            else if (rx) begin
              ksel_r  <= rx_data_i;
              wr_ok_r <= 1'b1;
            end
          end else if (rx) begin
            ksel_r <= rx_data_i;
            cnt_r  <= cnt_r + 5'd1;
            if (op_r == `OP_KEY_WRITE) cnt_r <= 5'd0;
            if (halt_cmd) join_act_r <= 1'b0;
            if (op_r == `OP_JOINCTL && locked && !halt_cmd) nak_r <= 1'b1;
            if (op_r == `OP_FACTORY_RESTORE) begin
              if (cnt_r == 5'd0 && rx_data_i != `FRM_ESCAPE) nak_r <= 1'b1;
              if (cnt_r == 5'd1 && rx_data_i != `NVR_CONF1) nak_r <= 1'b1;
              if (cnt_r == 5'd2 && rx_data_i != `FRM_ESCAPE) nak_r <= 1'b1;
              if (cnt_r == 5'd3 && (rx_data_i != `NVR_CONF2 || size_r != `NVR_SIZE))
                nak_r <= 1'b1;
              if (cnt_r == 5'd3) cnt_r <= 5'd0;
            end
          end
        end
        ST_KEY: if (rx) cnt_r <= cnt_r + 5'd1;
        ST_MSG: if (tx_ready_i) cnt_r <= cnt_r + 5'd1;
        ST_RESET: {nm0_r, nm1_r, nm2_r, sec_opts_r, pkt_opts_r} <= '0;
        default: ;
      endcase
    end
  end
endmodule

//--- tb/sec_event_regs_assertions.sv
module sec_event_regs_chk
  import sec_event_pkg::*;
(
  input wire logic       mclk_i,
  input wire logic       arst_n_i,
  input wire logic       rx_valid_i,
  input wire logic       tx_ready_i,
  input wire logic       rx_bytes_pending_i,
  input wire logic       join_start_i,
  input wire logic       join_done_i,
  input wire logic [7:0] legacy_event_mask_i,
  input wire logic       tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic       full_reset_o,
  input wire logic       fault_notice_line_o,
  input wire logic       join_active_indication_o,
  input wire logic [7:0] packet_options_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);
  // No host bytes, legacy mask clear, pending level up
  sequence s_quiet;
    (!rx_valid_i && legacy_event_mask_i == 8'h00 && rx_bytes_pending_i) [*3];
  endsequence
  sequence s_join_req;
    join_start_i && !join_done_i;
  endsequence
  chk_tx_byte_holds: assert property (
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte changed before it was taken");
  chk_legacy_blocks: assert property (
    legacy_event_mask_i != 8'h00 |-> !fault_notice_line_o)
    else $error("fault line high with legacy mask set");
  chk_fault_holds: assert property (
    s_quiet ##0 fault_notice_line_o |=>
      fault_notice_line_o || legacy_event_mask_i != 8'h00 || !rx_bytes_pending_i)
    else $error("fault line dropped without a host write");
  chk_reset_latched: assert property (
    full_reset_o |=> full_reset_o)
    else $error("full reset request released early");
  chk_reset_quiet: assert property (
    full_reset_o |-> !tx_valid_o)
    else $error("byte offered after full reset request");
  chk_options_write: assert property (
    $changed(packet_options_o) |->
      !$past(join_active_indication_o) && ($past(rx_valid_i) || $past(rx_valid_i, 2)
      || $past(full_reset_o)))
    else $error("packet options changed without an accepted write");
  chk_join_enter: assert property (
    s_join_req |=> join_active_indication_o)
    else $error("join active missing after join start");
  chk_join_leave: assert property (
    join_done_i && !join_start_i |=> !join_active_indication_o)
    else $error("join active stuck after join done");
endmodule

bind sec_event_regs sec_event_regs_chk u_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .rx_valid_i(rx_valid_i), .tx_ready_i(tx_ready_i),
  .rx_bytes_pending_i(rx_bytes_pending_i), .join_start_i(join_start_i),
  .join_done_i(join_done_i), .legacy_event_mask_i(legacy_event_mask_i),
  .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .full_reset_o(full_reset_o),
  .fault_notice_line_o(fault_notice_line_o),
  .join_active_indication_o(join_active_indication_o), .packet_options_o(packet_options_o)
);

//--- tb/uart_host_model.sv
module uart_host_model
  import sec_event_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            tx_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int stall = 0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    tx_ready_o = 1'b0;
  end
  // One frame byte per pulse, line inverted once released
  task automatic send(input byte_t b);
    @(posedge mclk_i);
    #1 rx_valid_o = 1'b1;
    rx_data_o = b;
    @(posedge mclk_i);
    #1 rx_valid_o = 1'b0;
    rx_data_o = ~b;
  endtask
  // Optional stall, then take one reply byte
  task automatic recv(output byte_t b);
    int n;
    n = 0;
    repeat (stall) @(posedge mclk_i);
    #1 tx_ready_o = 1'b1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (!tx_valid_i && n < 400);
    b = tx_valid_i ? tx_data_i : 8'hXX;
    #1 tx_ready_o = 1'b0;
  endtask
endmodule

//--- tb/sec_event_regs_tb_top.sv
`include "sec_event_map.svh"
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end
module sec_event_regs_tb_top
  import sec_event_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       mclk_i, arst_n_i = 0, tx_pk = 0, ack_rq = 0, ack_rx = 0, pend = 0;
  logic       plain = 0, enc = 0, jstart = 0, jpeer = 0, jdone = 0;
  logic [7:0] legacy = 0, err = 0, seq = 0;
  wire        rx_valid, tx_ready, tx_valid, full_rst, fault, jact;
  wire  [7:0] rx_data, tx_data, pkt;
  int         n_mismatch = 0, n_checks = 0;
  sec_event_regs DUT (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .tx_ready_i(tx_ready), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
    .full_reset_o(full_rst), .legacy_event_mask_i(legacy), .event_err_i(err),
    .tx_packet_done_i(tx_pk), .ack_requested_i(ack_rq), .ack_received_i(ack_rx),
    .rx_bytes_pending_i(pend), .rx_plain_pkt_i(plain), .rx_enc_pkt_i(enc), .rx_seq_i(seq),
    .join_start_i(jstart), .join_peer_seen_i(jpeer), .join_done_i(jdone),
    .fault_notice_line_o(fault), .join_active_indication_o(jact), .packet_options_o(pkt));
  uart_host_model host (.mclk_i(mclk_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .rx_valid_o(rx_valid), .rx_data_o(rx_data), .tx_ready_o(tx_ready));
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic pulse(ref logic s);
    tick(1);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic do_reset();
    tick(1);
    arst_n_i = 1'b0;
    tick(8);
    arst_n_i = 1'b1;
    tick(20);
  endtask
  task automatic frame(input byte_t q[$], input byte_t rsp);
    byte_t r;
    foreach (q[i]) host.send(q[i]);
    host.recv(r);
    `CHK("reply code", rsp, r)
  endtask
  task automatic wr(input byte_t a, input byte_t v, input byte_t rsp);
    frame('{8'hFF, 8'h03, 8'hFE, a & 8'h7F, v}, rsp);
  endtask
  task automatic rd(input byte_t a, input byte_t v);
    byte_t r;
    frame('{8'hFF, 8'h03, 8'hFE, 8'hFE, a & 8'h7F}, `FRM_ACK);
    host.recv(r);
    `CHK("read addr", a | 8'h80, r)
    host.recv(r);
    `CHK("read value", v, r)
  endtask
  task automatic key_wr(input byte_t sel);
    byte_t q[$] = '{8'hFF, 8'h14, 8'hFE, `ADDR_CMD, `OP_KEY_WRITE, sel};
    for (int i = 0; i < `KEY_BYTES; i++) q.push_back(8'h10 + byte_t'(i));
    frame(q, `FRM_ACK);
  endtask
  task automatic enc_pkt(input byte_t s);
    seq = s;
    pulse(enc);
  endtask
  task automatic t_regs();
    byte_t a[7] = '{8'hD0, 8'hD1, 8'hD2, 8'hD3, 8'h80, 8'h81, 8'h82};
    foreach (a[i]) wr(a[i], 8'hA0 + byte_t'(i), `FRM_ACK);
    foreach (a[i]) rd(a[i], 8'hA0 + byte_t'(i));
    `CHK("packet options", 8'hA3, pkt)
    rd(`ADDR_FLAG2, 8'h00);
    frame('{8'hFF, `CLR_SIZE, 8'hFE, `ADDR_CMD, `OP_KEY_CLEAR, `KSEL_NV}, `FRM_ACK);
    frame('{8'hFF, `CLR_SIZE, 8'hFE, `ADDR_CMD, `OP_KEY_CLEAR, `KSEL_VOL}, `FRM_ACK);
    rd(`RD_SEC_STATUS, 8'h00);
  endtask
  task automatic t_flags();
    wr(`ADDR_MASK0, 8'h10, `FRM_ACK);
    wr(`ADDR_MASK1, 8'h02, `FRM_ACK);
    tick(1);
    err = 8'hFF;
    tick(1);
    err = 8'h00;
    rd(`ADDR_FLAG0, 8'hFF);
    `CHK("fault on", 1'b1, fault)
    legacy = 8'h01;
    tick(1);
    `CHK("fault legacy", 1'b0, fault)
    legacy = 8'h00;
    wr(`ADDR_FLAG0, 8'hF0, `FRM_ACK);
    rd(`ADDR_FLAG0, 8'hF0);
    wr(`ADDR_FLAG0, 8'hFF, `FRM_ACK);
    rd(`ADDR_FLAG0, 8'hF0);
    wr(`ADDR_FLAG0, 8'hE0, `FRM_ACK);
    `CHK("fault off", 1'b0, fault)
    pend = 1'b1;
    tick(6);
    `CHK("fault pend", 1'b1, fault)
    wr(`ADDR_FLAG1, 8'h00, `FRM_ACK);
    rd(`ADDR_FLAG1, 8'h02);
    pend = 1'b0;
    rd(`ADDR_FLAG1, 8'h00);
    ack_rq = 1'b1;
    pulse(tx_pk);
    rd(`ADDR_FLAG1, 8'h00);
    pulse(ack_rx);
    ack_rq = 1'b0;
    rd(`ADDR_FLAG1, 8'h01);
    pulse(plain);
    enc_pkt(8'h05);
    enc_pkt(8'h06);
    rd(`ADDR_FLAG1, 8'h01);
    enc_pkt(8'h04);
    rd(`ADDR_FLAG1, 8'h09);
    enc_pkt(8'h07);
    rd(`ADDR_FLAG1, 8'h19);
    wr(`ADDR_SEC_OPTIONS, 8'h20, `FRM_ACK);
    pulse(plain);
    rd(`ADDR_FLAG1, 8'h1D);
    wr(`ADDR_FLAG1, 8'h00, `FRM_ACK);
  endtask
  task automatic t_join();
    pulse(jstart);
    rd(`RD_JOIN_STATUS, `JOIN_WAIT + `JOIN_ACTIVE_ADD);
    rd(`ADDR_FLAG1, 8'h20);
    wr(`ADDR_PKT_OPTIONS, 8'h55, `FRM_NACK);
    rd(`ADDR_PKT_OPTIONS, 8'hA3);
    pulse(jpeer);
    rd(`RD_JOIN_STATUS, `JOIN_PROGRESS + `JOIN_ACTIVE_ADD);
    frame('{8'hFF, 8'h04, 8'hFE, `ADDR_CMD, `OP_JOINCTL, 8'h00}, `FRM_ACK);
    `CHK("join halted", 1'b0, jact)
    pulse(jstart);
    pulse(jdone);
    `CHK("join done", 1'b0, jact)
    wr(`ADDR_FLAG1, 8'h00, `FRM_ACK);
  endtask
  task automatic t_keys();
    host.stall = 2;
    key_wr(`KSEL_VOL);
    rd(`RD_SEC_STATUS, 8'h02);
    key_wr(`KSEL_NV);
    rd(`RD_SEC_STATUS, 8'h06);
    frame('{8'hFF, `CLR_SIZE, 8'hFE, `ADDR_CMD, `OP_KEY_CLEAR, `KSEL_VOL}, `FRM_ACK);
    rd(`RD_SEC_STATUS, 8'h04);
    frame('{8'hFF, 8'h03, 8'hFE, `ADDR_CMD, `OP_KEY_RELOAD}, `FRM_ACK);
    rd(`RD_SEC_STATUS, 8'h06);
    frame('{8'hFF, `CLR_SIZE, 8'hFE, `ADDR_CMD, `OP_KEY_CLEAR, `KSEL_VOL}, `FRM_ACK);
    host.stall = 0;
    do_reset();
    rd(`RD_SEC_STATUS, 8'h06);
  endtask
  task automatic t_factory_config_restore_command();
    byte_t q[$] = '{8'hFF, `NVR_SIZE, 8'hFE, `ADDR_CMD, `OP_FACTORY_RESTORE,
                    8'hFE, `NVR_CONF1, 8'hFE, `NVR_CONF2};
    string msg = "\r\nConfiguration Reset\r\n";
    byte_t r;
    foreach (q[i]) host.send(q[i]);
    host.recv(r);
    if (r === `FRM_ACK) host.recv(r);
    for (int i = 0; i < `MSG_LEN; i++) begin
      if (i > 0) host.recv(r);
      `CHK("reset text", byte_t'(msg[i]), r)
    end
    repeat (50) if (full_rst !== 1'b1) @(posedge mclk_i);
    `CHK("full reset", 1'b1, full_rst)
    do_reset();
    rd(`ADDR_NVMASK2, 8'h00);
    rd(`RD_SEC_STATUS, 8'h00);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #500us;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    do_reset();
    t_regs();
    t_flags();
    t_join();
    t_keys();
    t_factory_config_restore_command();
    wrap_up();
  end
endmodule
